// File: design/cims_top.sv
`timescale 1ns/100ps
`include "cims_regs.svh"
module cims_top
	import cims_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] contact_in,
	input wire logic host_present,
	input wire logic option_five,
	input wire logic [1:0] alarm_active,
	input wire logic kp_mode_req,
	input wire logic [2:0] kp_mode,
	input wire logic kp_sp_req,
	input wire logic kp_sp_ext,
	input wire logic auto_req,
	input wire logic [2:0] auto_mode,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [2:0] mode,
	output logic sp_external,
	output logic integral_hold,
	output logic [1:0] alarm_ack,
	output logic key_up,
	output logic key_down,
	output logic key_view,
	output logic key_fast,
	output logic host_fail,
	output logic irq
);
	logic [4:0] s1_q, s2_q, s3_q, db_q, db_d;
	logic [15:0] dcnt_q [5];
	logic [4:0] armed_q, rise, fall, live, ext_rise, int_rise;
	logic [19:0] func_q;
	logic [1:0] ctrl_q;
	logic [25:0] tmo_q, wcnt_q;
	logic [4:0] stat_q, mask_q, ev;
	logic [2:0] mode_q, last_idx_q;
	logic last_v_q, sp_q, wd_fail_q, any_win;
	logic wr, rd, wd_on, wd_tog;
	logic [3:0] fsel [5];

	genvar g;
	generate
		for (g = 0; g < `CIMS_N_IN; g++) begin : g_in
			assign fsel[g] = func_q[4*g+:4];
			always_ff @(posedge clk) begin // see R18
				if (rst) begin
					dcnt_q[g] <= 16'h0000;
					db_q[g] <= 1'b0;
				end else if (s2_q[g] != s3_q[g] || s3_q[g] == db_q[g]) begin
					dcnt_q[g] <= 16'h0000;
				end else if (dcnt_q[g] == `CIMS_DEB_CYC) begin
					dcnt_q[g] <= 16'h0000;
					db_q[g] <= s3_q[g];
				end else begin
					dcnt_q[g] <= dcnt_q[g] + 16'h0001;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin // see R18
		if (rst) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			s3_q <= 5'h00;
			db_d <= 5'h00;
		end else begin
			s1_q <= contact_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			db_d <= db_q;
		end
	end
	assign rise = db_q & ~db_d; // see R18
	assign fall = ~db_q & db_d;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge clk) begin
		if (rst) begin
			func_q <= 20'h00000;
			ctrl_q <= 2'h0;
			mask_q <= 5'h00;
			tmo_q <= `CIMS_TMO_RST;
		end else if (wr) begin
			case (paddr)
			`CIMS_CTRL_OFS: ctrl_q <= pwdata[1:0];
			`CIMS_FUNC_OFS: func_q <= pwdata[19:0]; // see R1
			`CIMS_MASK_OFS: mask_q <= pwdata[4:0];
			`CIMS_TMO_OFS: tmo_q <= pwdata[25:0];
			default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (rd && !penable) begin
			case (paddr)
			`CIMS_CTRL_OFS: prdata <= {30'h0, ctrl_q};
			`CIMS_FUNC_OFS: prdata <= {12'h000, func_q};
			`CIMS_STAT_OFS: prdata <= {27'h0, stat_q};
			`CIMS_MASK_OFS: prdata <= {27'h0, mask_q};
			`CIMS_STATE_OFS: prdata <= {11'h000, host_fail, sp_q,
				mode_q, 3'h0, armed_q, 3'h0, live}; // see R10
			`CIMS_TMO_OFS: prdata <= {6'h00, tmo_q};
			default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Per-input serial status and setpoint-select closure decode
	always_comb begin
		for (int i = 0; i < `CIMS_N_IN; i++) begin
			live[i] = db_q[i] && (fsel[i] == CIMS_F_SERIAL); // see R10
			ext_rise[i] = rise[i] && (fsel[i] == CIMS_F_EXT_SP);
			int_rise[i] = rise[i] && (fsel[i] == CIMS_F_INT_SP);
		end
	end

	// A closure arms; override or opening disarms
	always_ff @(posedge clk) begin
		if (rst) begin
			armed_q <= 5'h00;
		end else begin
			for (int i = 0; i < `CIMS_N_IN; i++) begin
				if (rise[i]) begin
					armed_q[i] <= 1'b1;
				end else if (fall[i]) begin
					armed_q[i] <= 1'b0; // see R4
				end else if (kp_mode_req || auto_req) begin
					armed_q[i] <= 1'b0; // see R3
				end else if (|rise) begin
					armed_q[i] <= 1'b0; // see R3
				end
			end
		end
	end

	// Newest closure wins
	always_comb begin
		any_win = |rise;
	end
	always_ff @(posedge clk) begin // see R2
		if (rst) begin
			last_idx_q <= 3'h0;
			last_v_q <= 1'b0;
		end else begin
			for (int i = 0; i < `CIMS_N_IN; i++) begin
				if (rise[i]) begin
					last_idx_q <= 3'(i);
					last_v_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= CIMS_M_HOST;
		end else if (kp_mode_req) begin
			mode_q <= kp_mode; // see R3
		end else if (auto_req) begin
			mode_q <= auto_mode;
		end else if (any_win) begin
			for (int i = 0; i < `CIMS_N_IN; i++) begin
				if (rise[i]) begin
					case (fsel[i])
					CIMS_F_MAN_HOLD: mode_q <= CIMS_M_MAN_HOLD; // see R6
					CIMS_F_MAN_A: mode_q <= CIMS_M_MAN_A; // see R7
					CIMS_F_MAN_B: mode_q <= CIMS_M_MAN_B; // see R7
					CIMS_F_AUTO: mode_q <= CIMS_M_AUTO; // see R13
					CIMS_F_HOST: mode_q <= CIMS_M_HOST; // see R13
					default: ;
					endcase
				end
			end
		end
	end
	assign mode = mode_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			sp_q <= 1'b0;
		end else if (kp_sp_req) begin
			sp_q <= kp_sp_ext; // see R5
		end else begin
			for (int i = 0; i < `CIMS_N_IN; i++) begin
				if (rise[i] && fsel[i] == CIMS_F_EXT_SP) begin
					sp_q <= 1'b1; // see R12
				end else if (rise[i] && fsel[i] == CIMS_F_INT_SP) begin
					sp_q <= 1'b0; // see R12
				end
			end
		end
	end
	assign sp_external = sp_q;

	// One-cycle key and ack pulses on closure
	always_ff @(posedge clk) begin
		if (rst) begin
			key_up <= 1'b0;
			key_down <= 1'b0;
			key_view <= 1'b0;
			key_fast <= 1'b0;
			alarm_ack <= 2'b00;
			integral_hold <= 1'b0;
		end else begin
			key_up <= 1'b0;
			key_down <= 1'b0;
			key_view <= 1'b0;
			key_fast <= 1'b0;
			alarm_ack <= 2'b00;
			integral_hold <= 1'b0;
			for (int i = 0; i < `CIMS_N_IN; i++) begin
				if (rise[i] && fsel[i] == CIMS_F_UP) key_up <= 1'b1; // see R9
				if (rise[i] && fsel[i] == CIMS_F_DOWN) key_down <= 1'b1; // see R9
				if (rise[i] && fsel[i] == CIMS_F_VIEW) key_view <= 1'b1;
				if (rise[i] && fsel[i] == CIMS_F_FAST) key_fast <= 1'b1;
				if (rise[i] && fsel[i] == CIMS_F_ACK) begin
					alarm_ack <= alarm_active; // see R8
				end
				if (db_q[i] && fsel[i] == CIMS_F_INT_HOLD) begin
					integral_hold <= 1'b1; // see R11
				end
			end
		end
	end

	// Pulse monitor
	always_comb begin
		wd_on = 1'b0;
		wd_tog = 1'b0;
		for (int i = 0; i < `CIMS_N_IN; i++) begin
			if (fsel[i] == CIMS_F_WDOG) begin
				wd_on = ctrl_q[0] && option_five; // see R14
				wd_tog = wd_tog | rise[i] | fall[i];
			end
		end
	end

	always_ff @(posedge clk) begin // see R19
		if (rst || !wd_on || wd_tog) begin
			wcnt_q <= 26'h0000000;
			wd_fail_q <= 1'b0;
		end else if (wcnt_q >= tmo_q) begin
			wd_fail_q <= 1'b1; // see R17
		end else begin
			wcnt_q <= wcnt_q + 26'h0000001;
		end
	end
	assign host_fail = !host_present || (wd_on && wd_fail_q); // see R15 R16

	assign ev = {wd_fail_q, |alarm_ack, key_up | key_down, |fall, |rise};
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_q <= 5'h00;
		end else if (wr && paddr == `CIMS_STAT_OFS) begin
			stat_q <= (stat_q & ~pwdata[4:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end
	assign irq = |(stat_q & mask_q);

	property p_hold;
		@(posedge clk) disable iff (rst)
		(wd_on && !wd_tog && wcnt_q >= tmo_q) |=> wd_fail_q;
	endproperty
	a_hold: assert property (p_hold) else $error("no fail"); // see R17
	property p_tog;
		@(posedge clk) disable iff (rst) wd_tog |=> wcnt_q == 26'h0;
	endproperty
	a_tog: assert property (p_tog) else $error("no restart"); // see R19
	property p_kp;
		@(posedge clk) disable iff (rst) kp_mode_req |=> mode == $past(kp_mode);
	endproperty
	a_kp: assert property (p_kp) else $error("keypad lost"); // see R3
	property p_sp;
		@(posedge clk) disable iff (rst) kp_sp_req |=> sp_external == $past(kp_sp_ext);
	endproperty
	a_sp: assert property (p_sp) else $error("sp wrong"); // see R5
	property p_arm;
		@(posedge clk) disable iff (rst) (|fall) |=> ((armed_q & $past(fall)) == 5'h0);
	endproperty
	a_arm: assert property (p_arm) else $error("still armed"); // see R4
	property p_hf;
		@(posedge clk) disable iff (rst) !wd_on |-> host_fail == !host_present;
	endproperty
	a_hf: assert property (p_hf) else $error("host fail"); // see R15
	property p_key;
		@(posedge clk) disable iff (rst) key_up |=> !key_up || $past(|rise);
	endproperty
	a_key: assert property (p_key) else $error("key held"); // see R9
	property p_opt;
		@(posedge clk) disable iff (rst) !option_five |-> !wd_on;
	endproperty
	a_opt: assert property (p_opt) else $error("no option"); // see R14

	// Setpoint source picked by a closure
	sequence s_ext_pick;
		!kp_sp_req && (|ext_rise) && !(|int_rise);
	endsequence
	sequence s_int_pick;
		!kp_sp_req && (|int_rise) && !(|ext_rise);
	endsequence
	property p_ext;
		@(posedge clk) disable iff (rst) s_ext_pick |=> sp_external;
	endproperty
	a_ext: assert property (p_ext) else $error("ext sp lost"); // see R12
	property p_int;
		@(posedge clk) disable iff (rst) s_int_pick |=> !sp_external;
	endproperty
	a_int: assert property (p_int) else $error("int sp lost"); // see R12

	// Acknowledge only alarms active at the closure
	property p_ack;
		@(posedge clk) disable iff (rst)
		(alarm_ack & ~$past(alarm_active)) == 2'b00;
	endproperty
	a_ack: assert property (p_ack) else $error("late ack"); // see R8
	property p_ackc;
		@(posedge clk) disable iff (rst) (|alarm_ack) |-> $past(|rise);
	endproperty
	a_ackc: assert property (p_ackc) else $error("ack no close"); // see R8

	// Integral hold follows a closed input
	property p_ih;
		@(posedge clk) disable iff (rst) integral_hold |-> $past(|db_q);
	endproperty
	a_ih: assert property (p_ih) else $error("hold open"); // see R11

	// Down key pulse
	property p_kd;
		@(posedge clk) disable iff (rst)
		key_down |=> !key_down || $past(|rise);
	endproperty
	a_kd: assert property (p_kd) else $error("down held"); // see R9

	// Mode only moves on a request or closure
	property p_mode;
		@(posedge clk) disable iff (rst)
		$changed(mode) |-> $past(kp_mode_req || auto_req || (|rise));
	endproperty
	a_mode: assert property (p_mode) else $error("mode drift"); // see R13

	// Closure arms its input
	property p_armr;
		@(posedge clk) disable iff (rst)
		(|rise) |=> ((armed_q & $past(rise)) == $past(rise));
	endproperty
	a_armr: assert property (p_armr) else $error("not armed"); // see R4

	// Monitor disabled clears failure
	property p_wdoff;
		@(posedge clk) disable iff (rst) !wd_on |=> !wd_fail_q;
	endproperty
	a_wdoff: assert property (p_wdoff) else $error("fail kept"); // see R16
	property p_wdrise;
		@(posedge clk) disable iff (rst)
		$rose(wd_fail_q) |-> $past(wd_on && wcnt_q >= tmo_q);
	endproperty
	a_wdrise: assert property (p_wdrise) else $error("early fail"); // see R19

	// Missing host signal always fails
	property p_hp;
		@(posedge clk) disable iff (rst) !host_present |-> host_fail;
	endproperty
	a_hp: assert property (p_hp) else $error("host absent"); // see R15

	// Closure event is sticky
	property p_stat;
		@(posedge clk) disable iff (rst) (|rise) |=> stat_q[0];
	endproperty
	a_stat: assert property (p_stat) else $error("no event"); // see R18
endmodule // cims_top

// File: design/cims_regs.svh
`ifndef CIMS_REGS_SVH
`define CIMS_REGS_SVH
// Behaviour
// R1: Five contact inputs, each with its own selectable function code.
// R2: With several closed, the most recently closed input wins.
// R3: Keypad, automatic function or another input can override a closure.
// R4: An overridden input stays ignored until it opens and closes again.
// R5: Keypad remote setpoint beats a contact holding local setpoint.
// R6: Manual-hold closure enters manual mode at the last output.
// R7: Manual-preset closure enters manual mode at preset output a or b.
// R8: Acknowledge closure acknowledges active alarms once, not later ones.
// R9: Up or down key closure acts as one key press.
// R10: Serial-readable input only shows its state, no other effect. Its closure still sets status bit 0, which can raise irq.
// R11: Integral hold input suppresses PID reset while closed.
// R12: Setpoint select closure picks external or internal setpoint.
// R13: Auto-local or host-follow closure switches to that mode.
// R14: Pulse monitor offered only when five-input option is fitted.
// R15: Without the monitor, host failure follows host signal presence only.
// R16: Monitor runs only if assigned to an input and enabled.
// R17: Monitored input must toggle within the timeout or host fails.
// R18: Inputs are synchronised, debounced and edge detected.
// R19: Timeout counter restarts on every toggle and flags at limit.
`define CIMS_CTRL_OFS 12'h000
`define CIMS_FUNC_OFS 12'h004
`define CIMS_STAT_OFS 12'h008
`define CIMS_MASK_OFS 12'h00c
`define CIMS_STATE_OFS 12'h010
`define CIMS_TMO_OFS 12'h014
`define CIMS_CMD_OFS 12'h018
`define CIMS_N_IN 5
`define CIMS_DEB_CYC 16'd1000
`define CIMS_TMO_MIN_MS 400
`define CIMS_TMO_MAX_MS 2500
`define CIMS_CLK_KHZ 20000
`define CIMS_TMO_RST 26'd50000000
`endif

// File: design/cims_pkg.sv
package cims_pkg;
	typedef enum logic [3:0] {
		CIMS_F_NONE = 4'h0,
		CIMS_F_MAN_HOLD = 4'h1,
		CIMS_F_MAN_A = 4'h2,
		CIMS_F_MAN_B = 4'h3,
		CIMS_F_ACK = 4'h4,
		CIMS_F_UP = 4'h5,
		CIMS_F_DOWN = 4'h6,
		CIMS_F_SERIAL = 4'h7,
		CIMS_F_VIEW = 4'h8,
		CIMS_F_FAST = 4'h9,
		CIMS_F_INT_HOLD = 4'ha,
		CIMS_F_EXT_SP = 4'hb,
		CIMS_F_INT_SP = 4'hc,
		CIMS_F_AUTO = 4'hd,
		CIMS_F_HOST = 4'he,
		CIMS_F_WDOG = 4'hf
	} cims_func_e;
	typedef enum logic [2:0] {
		CIMS_M_HOST = 3'b000,
		CIMS_M_AUTO = 3'b001,
		CIMS_M_MAN_HOLD = 3'b010,
		CIMS_M_MAN_A = 3'b011,
		CIMS_M_MAN_B = 3'b100
	} cims_mode_e;
endpackage

// File: verification/cims_contact_model.sv
`timescale 1ns/100ps
module cims_contact_model (
	input wire logic clk,
	input wire logic [4:0] close_req,
	input wire logic pulse_en,
	input wire logic [15:0] pulse_half,
	output logic [4:0] contact_in
);
	logic [15:0] cnt_q = 16'h0000;
	logic pulse_q = 1'b0;
	// Host pulse on input 4 keeps toggling while enabled
	always_ff @(posedge clk) begin
		if (!pulse_en) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q >= pulse_half) begin
			cnt_q <= 16'h0000;
			pulse_q <= !pulse_q;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	assign contact_in = pulse_en ? {pulse_q, close_req[3:0]} : close_req;
endmodule // cims_contact_model

// File: verification/test_contact_input_mode_selector.sv
`timescale 1ns/100ps
module test_contact_input_mode_selector import cims_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, host_present = 1'b1, kp_mode_req = 1'b0;
	logic kp_sp_req = 1'b0, kp_sp_ext = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pulse_en = 1'b0, pready, pslverr, sp_external;
	logic integral_hold, key_up, key_down, key_view, key_fast, host_fail, irq;
	logic [4:0] close_req = 5'h00, contact_in;
	logic [1:0] alarm_active = 2'h0, alarm_ack;
	logic [2:0] kp_mode = 3'h0, mode;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	int err_total = 0, check_count = 0;
	always #25 clk = ~clk;
	cims_contact_model partner (.clk(clk), .close_req(close_req),
		.pulse_en(pulse_en), .pulse_half(16'h05dc), .contact_in(contact_in));
	cims_top DUT (.clk(clk), .rst(rst), .contact_in(contact_in),
		.host_present(host_present), .option_five(1'b1),
		.alarm_active(alarm_active), .kp_mode_req(kp_mode_req),
		.kp_mode(kp_mode), .kp_sp_req(kp_sp_req), .kp_sp_ext(kp_sp_ext),
		.auto_req(1'b0), .auto_mode(3'h0), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mode(mode),
		.sp_external(sp_external), .integral_hold(integral_hold),
		.alarm_ack(alarm_ack), .key_up(key_up), .key_down(key_down),
		.key_view(key_view), .key_fast(key_fast), .host_fail(host_fail),
		.irq(irq));
	task finish_test();
		$display("Errors %0d of %0d checks", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			chk(32'h0, 32'h1);
			finish_test();
		end
		@(negedge clk);
	endtask
	function automatic logic [31:0] obs(input int s);
		case (s)
			0: obs = {29'h0, mode};
			1: obs = {31'h0, sp_external};
			2: obs = {30'h0, alarm_ack};
			4: obs = {31'h0, key_up};
			5: obs = {31'h0, integral_hold};
			default: obs = {31'h0, host_fail};
		endcase
	endfunction
	task wait_obs(input int s, input logic [31:0] exp);
		int n;
		n = 0;
		while (obs(s) !== exp && n < 6000) begin
			@(negedge clk);
			n++;
		end
		chk(obs(s), exp);
		if (n == 6000) begin
			finish_test();
		end
	endtask
	task kp(input logic sp, input logic [2:0] m);
		@(posedge clk);
		kp_mode <= m;
		kp_mode_req <= !sp;
		kp_sp_ext <= 1'b1;
		kp_sp_req <= sp;
		@(posedge clk);
		kp_mode_req <= 1'b0;
		kp_sp_req <= 1'b0;
	endtask
	task scn_reset();
		chk({29'h0, mode}, {29'h0, CIMS_M_HOST});
		chk({31'h0, host_fail}, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h02faf080);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h004, 32'h000f4c21);
	endtask
	task scn_modes();
		close_req <= 5'h01;
		wait_obs(0, {29'h0, CIMS_M_MAN_HOLD});
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 12'h00c, 32'h0000001f);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 12'h008, 32'h0000001f);
		chk({31'h0, irq}, 32'h0);
		close_req <= 5'h03;
		wait_obs(0, {29'h0, CIMS_M_MAN_A});
		kp(1'b0, CIMS_M_AUTO);
		wait_obs(0, {29'h0, CIMS_M_AUTO});
		repeat (2000) @(negedge clk);
		chk({29'h0, mode}, {29'h0, CIMS_M_AUTO});
		close_req <= 5'h01;
		repeat (1500) @(posedge clk);
		close_req <= 5'h03;
		wait_obs(0, {29'h0, CIMS_M_MAN_A});
	endtask
	task scn_setpoint();
		kp(1'b1, 3'h0);
		wait_obs(1, 32'h1);
		close_req <= 5'h07;
		wait_obs(1, 32'h0);
		kp(1'b1, 3'h0);
		wait_obs(1, 32'h1);
	endtask
	task scn_ack();
		alarm_active <= 2'h3;
		close_req <= 5'h0f;
		wait_obs(2, 32'h3);
	endtask
	task scn_keys();
		apb(1'b1, 12'h004, 32'h000f40a5);
		close_req <= 5'h00;
		repeat (1100) @(negedge clk);
		close_req <= 5'h03;
		wait_obs(4, 32'h1);
		wait_obs(5, 32'h1);
	endtask
	task scn_watchdog();
		apb(1'b1, 12'h014, 32'h00000bb8);
		apb(1'b1, 12'h000, 32'h00000001);
		pulse_en <= 1'b1;
		repeat (8000) @(negedge clk);
		chk({31'h0, host_fail}, 32'h0);
		pulse_en <= 1'b0;
		wait_obs(3, 32'h1);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		scn_reset();
		scn_modes();
		scn_setpoint();
		scn_ack();
		scn_keys();
		scn_watchdog();
		finish_test();
	end
endmodule // test_contact_input_mode_selector
